// file: dv/irq_partner_model.sv
// Stand-in for the platform interrupt controller and the trap logic
module irq_partner_model
    import sup_irq_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Bench requests
    input wire irq_lines_s i_want,
    // Towards the block
    output irq_lines_s o_lines,
    // Trap logic side
    input wire irq_out_s i_irq,
    output logic [7:0] o_takes
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Controller lines are level; held low while the hart resets
    assign o_lines = i_rst ? '0 : i_want;

    // ==========================================================
    // One trap entry per rising supervisor take request
    logic take_q;
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            take_q <= 1'b0;
            o_takes <= 8'h00;
        end
        else
        begin
            take_q <= i_irq.super_take;
            o_takes <= o_takes + {7'h00, i_irq.super_take && !take_q};
        end
    end
endmodule // irq_partner_model

// file: dv/sup_irq_csrs_props.sv
// Port-level checks for the supervisor interrupt CSR block
`include "sup_irq_regs.svh"

module sup_irq_csrs_props
    import sup_irq_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Block inputs
    input wire csr_req_s i_csr,
    input wire priv_e i_priv,
    input wire logic i_super_global_en,
    input wire logic i_user_global_en,
    input wire irq_lines_s i_lines,
    // Block outputs
    input wire csr_resp_s o_csr,
    input wire irq_out_s o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // ==========================================================
    // Request shapes
    sequence s_user_perf;
        i_csr.valid && i_priv == PRIV_USER && i_csr.addr >= `ADDR_HPM_FIRST
            && i_csr.addr <= `ADDR_HPM_LAST;
    endsequence
    sequence s_sup_view;
        i_csr.valid && i_priv != PRIV_USER
            && (i_csr.addr == `ADDR_SUP_PENDING || i_csr.addr == `ADDR_SUP_ENABLE);
    endsequence
    sequence s_pend_read;
        i_csr.valid && i_priv != PRIV_USER && i_csr.addr == `ADDR_SUP_PENDING;
    endsequence

    // ==========================================================
    // Register access
    a_perf_user_trap: assert property (s_user_perf |=> o_csr.done && o_csr.illegal)
        else $error("user perf counter read not refused");
    a_illegal_no_data: assert property (o_csr.illegal |-> o_csr.done && o_csr.rdata == '0)
        else $error("refused access returned data");
    a_sup_view_mask: assert property (s_sup_view |=> !o_csr.illegal
        && (o_csr.rdata & ~64'h333) == '0)
        else $error("supervisor view shows reserved bits");
    a_ipi_sets_soft: assert property (i_lines.ipi ##1 s_pend_read |=> o_csr.rdata[1])
        else $error("ipi did not set soft pending");
    a_ext_line_read: assert property (s_pend_read ##0 i_lines.user_ext |=> o_csr.rdata[8])
        else $error("ext line missing from read");

    // ==========================================================
    // Interrupt outputs
    a_utimer_source: assert property (o_irq.takeable[4] |-> $past(i_lines.user_timer))
        else $error("user timer takeable without line");
    a_sext_source: assert property (o_irq.takeable[9] |-> $past(i_lines.super_ext))
        else $error("super ext takeable without line");
    a_sup_gl_block: assert property ((i_priv == PRIV_SUPER && !i_super_global_en) [*3]
        |-> !o_irq.super_take)
        else $error("super take with global enable clear");
    a_user_mode_only: assert property ((i_priv != PRIV_USER || !i_user_global_en) [*3]
        |-> !o_irq.user_take)
        else $error("user take outside user mode");
endmodule // sup_irq_csrs_props

bind supervisor_interrupt_csrs sup_irq_csrs_props chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_csr(i_csr), .i_priv(i_priv), .i_super_global_en(i_super_global_en),
    .i_user_global_en(i_user_global_en), .i_lines(i_lines), .o_csr(o_csr), .o_irq(o_irq));

// file: dv/supervisor_interrupt_csrs_tb.sv
// Self-checking bench for the supervisor interrupt CSR block
`include "sup_irq_regs.svh"

module supervisor_interrupt_csrs_tb
    import sup_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    localparam logic [11:0] PND = `ADDR_SUP_PENDING;
    localparam logic [11:0] ENA = `ADDR_SUP_ENABLE;
    localparam logic [11:0] GTE = `ADDR_CTR_GATE;
    localparam logic [11:0] SCR = `ADDR_SUP_SCRATCH;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    csr_req_s csr_req = '0;
    priv_e priv = PRIV_SUPER;
    logic retire = 1'b0;
    irq_lines_s want = '0;
    logic [1:0] gie = 2'b11;
    irq_lines_s lines;
    csr_resp_s resp;
    irq_out_s irq;
    logic [7:0] takes;
    logic ill_q;
    logic [63:0] rd_q;
    int failures = 0;
    int check_count = 0;

    irq_partner_model far_u (.i_sys_clk(sys_clk), .i_rst(rst), .i_want(want),
        .o_lines(lines), .i_irq(irq), .o_takes(takes));
    supervisor_interrupt_csrs dut_u (.i_sys_clk(sys_clk), .i_rst(rst), .i_csr(csr_req),
        .i_priv(priv), .i_super_global_en(gie[1]), .i_user_global_en(gie[0]),
        .i_lines(lines), .i_retire(retire), .o_csr(resp), .o_irq(irq));

    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic stop_test();
        if (failures == 0 && check_count > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // Valid stays up so requests can run back to back
    task automatic acc(input csr_op_e op, input logic [11:0] a, input logic [63:0] wd,
                       input priv_e pv);
        csr_req = '{1'b1, op, a, wd};
        priv = pv;
        @(negedge sys_clk);
        check(resp.done, 1'b1, "answer");
        ill_q = resp.illegal;
        rd_q = resp.rdata;
    endtask

    task automatic tick(input int n);
        csr_req.valid = 1'b0;
        repeat (n) @(negedge sys_clk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_soft();
        acc(CSR_SWAP_OP, ENA, 64'hFFF, PRIV_SUPER);
        acc(CSR_SWAP_OP, PND, 64'h3, PRIV_SUPER);
        acc(CSR_SETBITS_OP, PND, '0, PRIV_SUPER);
        check(rd_q, 64'h3, "soft set");
        acc(CSR_SETBITS_OP, ENA, '0, PRIV_SUPER);
        check(rd_q, 64'h333, "enable view");
        tick(3);
        check(irq.takeable, 12'h003, "takeable");
        check(irq.super_take, 1'b1, "super take");
        acc(CSR_CLEARBITS_OP, ENA, 64'h2, PRIV_SUPER);
        tick(3);
        check(irq.takeable, 12'h001, "soft masked");
        acc(CSR_SWAP_OP, PND, '0, PRIV_SUPER);
        acc(CSR_SETBITS_OP, PND, '0, PRIV_SUPER);
        check(rd_q, '0, "soft cleared");
    endtask

    task automatic t_views();
        acc(CSR_SWAP_OP, `ADDR_MACH_ENABLE, 64'hFFF, PRIV_MACHINE);
        acc(CSR_SWAP_OP, ENA, '0, PRIV_SUPER);
        acc(CSR_SETBITS_OP, `ADDR_MACH_ENABLE, '0, PRIV_MACHINE);
        check(rd_q, 64'h888, "reserved kept");
        acc(CSR_SWAP_OP, PND, '1, PRIV_SUPER);
        acc(CSR_SWAP_OP, `ADDR_MACH_PENDING, '0, PRIV_MACHINE);
        check(rd_q, 64'h103, "writable pending");
    endtask

    task automatic t_user_ext();
        acc(CSR_SWAP_OP, ENA, 64'h333, PRIV_SUPER);
        want.user_ext = 1'b1;
        acc(CSR_SETBITS_OP, PND, 64'h1, PRIV_SUPER);
        check(rd_q, 64'h100, "line in read");
        want.user_ext = 1'b0;
        acc(CSR_SETBITS_OP, PND, '0, PRIV_SUPER);
        check(rd_q, 64'h001, "line not stored");
        acc(CSR_SETBITS_OP, PND, 64'h100, PRIV_SUPER);
        tick(3);
        check(irq.takeable, 12'h101, "stored ext");
        priv = PRIV_USER;
        tick(3);
        check(irq.user_take, 1'b1, "user take");
        gie = 2'b10;
        tick(3);
        check(irq.user_take, 1'b0, "user gl off");
        gie = 2'b11;
        acc(CSR_CLEARBITS_OP, ENA, 64'h100, PRIV_SUPER);
        tick(3);
        check(irq.takeable, 12'h001, "ext masked");
        acc(CSR_SWAP_OP, PND, '0, PRIV_SUPER);
    endtask

    task automatic t_lines();
        logic [7:0] n0;
        n0 = takes;
        want.super_ext = 1'b1;
        want.user_timer = 1'b1;
        acc(CSR_SWAP_OP, ENA, 64'h333, PRIV_SUPER);
        tick(3);
        check(irq.takeable, 12'h210, "line takeable");
        gie = 2'b01;
        tick(3);
        check(irq.super_take, 1'b0, "gl blocks");
        priv = PRIV_USER;
        tick(3);
        check(irq.super_take, 1'b1, "user mode admits");
        check(takes, n0 + 8'h02, "trap entries");
        want = '0;
        gie = 2'b11;
        priv = PRIV_SUPER;
        tick(3);
    endtask

    task automatic t_ipi();
        want.ipi = 1'b1;
        tick(1);
        want.ipi = 1'b0;
        acc(CSR_SETBITS_OP, PND, '0, PRIV_SUPER);
        check(rd_q, 64'h2, "ipi sets");
        want.ipi = 1'b1;
        acc(CSR_CLEARBITS_OP, PND, 64'h2, PRIV_SUPER);
        want.ipi = 1'b0;
        acc(CSR_SWAP_OP, PND, '0, PRIV_SUPER);
        check(rd_q, 64'h2, "ipi beats clear");
    endtask

    task automatic t_gate();
        acc(CSR_SETBITS_OP, `ADDR_CYCLE, '0, PRIV_USER);
        check(ill_q, 1'b1, "gate closed");
        acc(CSR_SWAP_OP, GTE, '1, PRIV_SUPER);
        acc(CSR_SETBITS_OP, GTE, '0, PRIV_SUPER);
        check(rd_q, 64'h7, "fixed gate bits");
        for (int i = 0; i < 3; i++)
        begin
            acc(CSR_SETBITS_OP, `ADDR_CYCLE + 12'(i), '0, PRIV_USER);
            check(ill_q, 1'b0, "gate open");
        end
        acc(CSR_SETBITS_OP, `ADDR_HPM_FIRST, '0, PRIV_USER);
        check(ill_q, 1'b1, "perf trap");
        acc(CSR_CLEARBITS_OP, GTE, 64'h2, PRIV_SUPER);
        acc(CSR_SETBITS_OP, `ADDR_TIME, '0, PRIV_USER);
        check(ill_q, 1'b1, "time gated");
    endtask

    task automatic t_scratch();
        acc(CSR_SWAP_OP, SCR, 64'hA5A5_5A5A_0F0F_F0F0, PRIV_SUPER);
        acc(CSR_CLEARBITS_OP, SCR, 64'hFFFF_0000_0000_0000, PRIV_SUPER);
        check(rd_q, 64'hA5A5_5A5A_0F0F_F0F0, "scratch");
        acc(CSR_SETBITS_OP, SCR, '0, PRIV_SUPER);
        check(rd_q, 64'h0000_5A5A_0F0F_F0F0, "scratch rmw");
    endtask

    task automatic t_counters();
        acc(CSR_SWAP_OP, `ADDR_MINSTRET, 64'h10, PRIV_MACHINE);
        retire = 1'b1;
        tick(3);
        retire = 1'b0;
        acc(CSR_SETBITS_OP, `ADDR_INSTRET, '0, PRIV_SUPER);
        check(rd_q, 64'h13, "retired count");
        acc(CSR_SWAP_OP, ENA, 64'h20, PRIV_SUPER);
        acc(CSR_SWAP_OP, `ADDR_TIMER_CMP, '0, PRIV_MACHINE);
        tick(3);
        check(irq.takeable, 12'h020, "timer due");
        acc(CSR_SWAP_OP, `ADDR_TIMER_CMP, '1, PRIV_MACHINE);
        tick(3);
        check(irq.takeable, 12'h000, "timer cleared");
    endtask

    // ==========================================================
    // Main sequence and hang guard
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        tick(1);
        t_soft();
        t_views();
        t_user_ext();
        t_lines();
        t_ipi();
        t_gate();
        t_scratch();
        t_counters();
        stop_test();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("[FAIL] %0t timeout", $time);
        stop_test();
    end
endmodule // supervisor_interrupt_csrs_tb

// file: src/sup_irq_pkg.sv
// Types shared by the interrupt CSR block
package sup_irq_pkg;

    typedef enum logic [1:0] {PRIV_USER, PRIV_SUPER, PRIV_MACHINE} priv_e;

    typedef enum logic [1:0] {CSR_SWAP_OP, CSR_SETBITS_OP, CSR_CLEARBITS_OP} csr_op_e;

    typedef struct packed {
        logic valid;
        csr_op_e op;
        logic [11:0] addr;
        logic [63:0] wdata;
    } csr_req_s;

    typedef struct packed {
        logic done;
        logic illegal;
        logic [63:0] rdata;
    } csr_resp_s;

    typedef struct packed {
        logic ipi;
        logic super_ext;
        logic user_ext;
        logic user_timer;
        logic mach_soft;
        logic mach_timer;
        logic mach_ext;
    } irq_lines_s;

    typedef struct packed {
        logic super_take;
        logic user_take;
        logic [11:0] takeable;
    } irq_out_s;

endpackage

// file: src/sup_irq_regs.svh
// Register numbers, bit positions, masks and reset values of the interrupt CSR block
//
// Notes on behaviour
// - Writing 1 sets supervisor soft pending, writing 0 clears it.
// - Supervisor soft interrupt is not taken while its enable is clear.
// - An interprocessor interrupt sets the supervisor soft pending bit.
// - Writing 1 sets user soft pending, writing 0 clears it.
// - User soft masked by its enable; both read zero without user interrupts.
// - Only supervisor soft, user soft and user external pending accept writes.
// - Supervisor timer pending is masked by its enable; a clearing mechanism exists.
// - User timer pending masked by its enable; both zero without user interrupts.
// - Supervisor external pending is masked by its enable.
// - User external request is stored bit OR controller line.
// - Reads of user external pending return stored bit OR controller line.
// - Set and clear operations modify only the stored user external bit.
// - User external masked by its enable; both zero without user interrupts.
// - Supervisor views hold no state; they access the machine-level fields.
// - Bits 3, 7 and 11 are reserved in supervisor views and preserved.
// - User read of a counter with its gate bit clear is illegal.
// - User read of a counter with its gate bit set completes normally.
// - The gate register always exists; some bits are fixed at zero.
// - Scratch register stores the written value and nothing more.
// - A timer compare schedules interrupts against the real-time counter.
// - Cycle, time and retired counters can be written from machine level.
// - In supervisor mode, a clear global enable blocks supervisor interrupts.
`ifndef SUP_IRQ_REGS_SVH
`define SUP_IRQ_REGS_SVH

// ==========================================================================
// Register numbers
`define ADDR_SUP_ENABLE 12'h104
`define ADDR_CTR_GATE 12'h106
`define ADDR_SUP_SCRATCH 12'h140
`define ADDR_SUP_PENDING 12'h144
`define ADDR_MACH_ENABLE 12'h304
`define ADDR_MACH_PENDING 12'h344
`define ADDR_TIMER_CMP 12'h7C0
`define ADDR_MCYCLE 12'hB00
`define ADDR_MTIME 12'hB01
`define ADDR_MINSTRET 12'hB02
`define ADDR_CYCLE 12'hC00
`define ADDR_TIME 12'hC01
`define ADDR_INSTRET 12'hC02
`define ADDR_HPM_FIRST 12'hC03
`define ADDR_HPM_LAST 12'hC1F
`define GATE_IDX_HI 4

// ==========================================================================
// Interrupt bit positions
`define BIT_USER_SOFT 0
`define BIT_SUPER_SOFT 1
`define BIT_MACH_SOFT 3
`define BIT_USER_TIMER 4
`define BIT_SUPER_TIMER 5
`define BIT_MACH_TIMER 7
`define BIT_USER_EXT 8
`define BIT_SUPER_EXT 9
`define BIT_MACH_EXT 11

// ==========================================================================
// Masks and reset values
`define USER_IRQ_ON 1'b1
`define USER_BITS 12'h111
`define SUPER_BITS 12'h222
`define SUP_VIEW_MASK 12'h333
`define PEND_SW_MASK 12'h103
`define MACH_EN_MASK 12'hBBB
`define GATE_WR_MASK 32'h0000_0007
`define IRQ_RESET 12'h000
`define GATE_RESET 32'h0000_0000
`define CTR_RESET 64'h0000_0000_0000_0000
`define CMP_RESET 64'hFFFF_FFFF_FFFF_FFFF

`endif

// file: src/supervisor_interrupt_csrs.sv
// Supervisor interrupt pending/enable views, counter gate and scratch
`include "sup_irq_regs.svh"

module supervisor_interrupt_csrs
    import sup_irq_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,

    // Register access instruction
    input wire csr_req_s i_csr,
    input wire priv_e i_priv,

    // Status register enables
    input wire logic i_super_global_en,
    input wire logic i_user_global_en,

    // Interrupt sources
    input wire irq_lines_s i_lines,
    input wire logic i_retire,

    // Results
    output csr_resp_s o_csr,
    output irq_out_s o_irq
);

    // ======================================================================
    // Read-modify-write helper
    function automatic logic [63:0] rmw_value
    (
        input csr_op_e op,
        input logic [63:0] old,
        input logic [63:0] wd
    );
        logic [63:0] res;
        res = wd;
        unique case (op)
            CSR_SWAP_OP: res = wd;
            CSR_SETBITS_OP: res = old | wd;
            CSR_CLEARBITS_OP: res = old & ~wd;
        endcase
        return res;
    endfunction

    function automatic logic [11:0] merge_bits
    (
        input logic [11:0] old,
        input logic [11:0] val,
        input logic [11:0] mask
    );
        return (old & ~mask) | (val & mask);
    endfunction

    // ======================================================================
    // State
    logic [11:0] sw_pend;
    logic [11:0] irq_enable;
    logic [31:0] ctr_gate;
    logic [63:0] scratch;
    logic [63:0] cycle_ctr;
    logic [63:0] retired_ctr;

    logic [63:0] time_val;
    logic [63:0] cmp_val;
    logic timer_irq;

    // ======================================================================
    // Address decode
    wire [11:0] addr = i_csr.addr;
    wire hit_s_pend = (addr == `ADDR_SUP_PENDING);
    wire hit_s_en = (addr == `ADDR_SUP_ENABLE);
    wire hit_m_pend = (addr == `ADDR_MACH_PENDING);
    wire hit_m_en = (addr == `ADDR_MACH_ENABLE);
    wire hit_gate = (addr == `ADDR_CTR_GATE);
    wire hit_scratch = (addr == `ADDR_SUP_SCRATCH);
    wire hit_cmp = (addr == `ADDR_TIMER_CMP);
    wire hit_mcycle = (addr == `ADDR_MCYCLE);
    wire hit_mtime = (addr == `ADDR_MTIME);
    wire hit_minstret = (addr == `ADDR_MINSTRET);
    wire hit_cycle = (addr == `ADDR_CYCLE);
    wire hit_time = (addr == `ADDR_TIME);
    wire hit_instret = (addr == `ADDR_INSTRET);
    wire hit_hpm = (addr >= `ADDR_HPM_FIRST) && (addr <= `ADDR_HPM_LAST);

    wire hit_super = hit_s_pend | hit_s_en | hit_gate | hit_scratch;
    wire hit_mach = hit_m_pend | hit_m_en | hit_cmp | hit_mcycle | hit_mtime | hit_minstret;
    wire hit_ctr = hit_cycle | hit_time | hit_instret | hit_hpm;
    wire hit_any = hit_super | hit_mach | hit_ctr;

    // ======================================================================
    // Access checks
    wire is_user = (i_priv == PRIV_USER);
    wire is_super = (i_priv == PRIV_SUPER);
    wire is_mach = (i_priv == PRIV_MACHINE);

    // Counter addresses share their low five bits with the gate index
    wire [`GATE_IDX_HI:0] gate_idx = addr[`GATE_IDX_HI:0];
    wire gate_open = ctr_gate[gate_idx];
    wire gate_block = hit_ctr & is_user & ~gate_open;

    // A set or clear with zero operand is a pure read
    wire wr_attempt = (i_csr.op == CSR_SWAP_OP) | (|i_csr.wdata);
    wire ro_write = hit_ctr & wr_attempt;
    wire priv_low = (hit_super & is_user) | (hit_mach & ~is_mach);

    wire bad = ~hit_any | priv_low | gate_block | ro_write;
    wire acc_ok = i_csr.valid & ~bad;
    wire illegal = i_csr.valid & bad;

    // ======================================================================
    // Pending view
    wire [11:0] user_keep = `USER_IRQ_ON ? ~12'h000 : ~`USER_BITS;

    wire [11:0] hw_user_ext = 12'(i_lines.user_ext) << `BIT_USER_EXT;
    wire [11:0] hw_user_tmr = 12'(i_lines.user_timer) << `BIT_USER_TIMER;
    wire [11:0] hw_super_tmr = 12'(timer_irq) << `BIT_SUPER_TIMER;
    wire [11:0] hw_super_ext = 12'(i_lines.super_ext) << `BIT_SUPER_EXT;
    wire [11:0] hw_mach_soft = 12'(i_lines.mach_soft) << `BIT_MACH_SOFT;
    wire [11:0] hw_mach_tmr = 12'(i_lines.mach_timer) << `BIT_MACH_TIMER;
    wire [11:0] hw_mach_ext = 12'(i_lines.mach_ext) << `BIT_MACH_EXT;

    wire [11:0] hw_pend_raw = hw_user_ext | hw_user_tmr | hw_super_tmr | hw_super_ext
        | hw_mach_soft | hw_mach_tmr | hw_mach_ext;
    wire [11:0] hw_pend = hw_pend_raw & user_keep;

    // Stored bit and controller line both raise user external
    wire [11:0] pend_live = sw_pend | hw_pend;

    // Supervisor views are windows onto the machine fields
    wire [11:0] s_pend_view = pend_live & `SUP_VIEW_MASK;
    wire [11:0] s_en_view = irq_enable & `SUP_VIEW_MASK;

    // ======================================================================
    // Pending write
    wire pend_wr = acc_ok & (hit_s_pend | hit_m_pend);
    // Old value is the stored bit only, so the line never latches
    wire [63:0] pend_old = 64'(sw_pend);
    wire [63:0] pend_rmw = rmw_value(i_csr.op, pend_old, i_csr.wdata);
    wire [11:0] pend_mask = `PEND_SW_MASK & user_keep;

    wire [11:0] pend_wr_val = merge_bits(sw_pend, pend_rmw[11:0], pend_mask);
    wire [11:0] pend_after_wr = pend_wr ? pend_wr_val : sw_pend;

    // Interprocessor request wins over a clearing write in the same cycle
    wire [11:0] ipi_set = 12'(i_lines.ipi) << `BIT_SUPER_SOFT;
    wire [11:0] next_sw_pend = pend_after_wr | ipi_set;

    // ======================================================================
    // Enable write
    wire en_wr_s = acc_ok & hit_s_en;
    wire en_wr_m = acc_ok & hit_m_en;
    wire [63:0] en_old = 64'(hit_s_en ? s_en_view : irq_enable);
    wire [63:0] en_rmw = rmw_value(i_csr.op, en_old, i_csr.wdata);

    // Reserved machine positions keep their value on supervisor writes
    wire [11:0] en_mask_s = `SUP_VIEW_MASK & user_keep;
    wire [11:0] en_mask_m = `MACH_EN_MASK & user_keep;
    wire [11:0] en_mask = en_wr_s ? en_mask_s : en_mask_m;
    wire [11:0] en_merged = merge_bits(irq_enable, en_rmw[11:0], en_mask);
    wire [11:0] next_irq_enable = (en_wr_s | en_wr_m) ? en_merged : irq_enable;

    // ======================================================================
    // Gate and scratch writes
    wire gate_wr = acc_ok & hit_gate;
    wire [63:0] gate_rmw = rmw_value(i_csr.op, 64'(ctr_gate), i_csr.wdata);
    // Performance counter gates are fixed at zero: user reads of them always trap
    wire [31:0] gate_merged = (ctr_gate & ~`GATE_WR_MASK) | (gate_rmw[31:0] & `GATE_WR_MASK);
    wire [31:0] next_ctr_gate = gate_wr ? gate_merged : ctr_gate;

    wire scratch_wr = acc_ok & hit_scratch;
    wire [63:0] scratch_rmw = rmw_value(i_csr.op, scratch, i_csr.wdata);
    wire [63:0] next_scratch = scratch_wr ? scratch_rmw : scratch;

    // ======================================================================
    // Counters
    wire cyc_wr = acc_ok & hit_mcycle;
    wire ret_wr = acc_ok & hit_minstret;
    wire time_wr = acc_ok & hit_mtime;
    wire cmp_wr = acc_ok & hit_cmp;

    wire [63:0] cyc_rmw = rmw_value(i_csr.op, cycle_ctr, i_csr.wdata);
    wire [63:0] ret_rmw = rmw_value(i_csr.op, retired_ctr, i_csr.wdata);
    wire [63:0] time_rmw = rmw_value(i_csr.op, time_val, i_csr.wdata);
    wire [63:0] cmp_rmw = rmw_value(i_csr.op, cmp_val, i_csr.wdata);
    wire [63:0] timer_wdata = hit_cmp ? cmp_rmw : time_rmw;

    wire [63:0] cyc_inc = cycle_ctr + 64'h0000_0000_0000_0001;
    wire [63:0] ret_inc = retired_ctr + 64'(i_retire);
    wire [63:0] next_cycle_ctr = cyc_wr ? cyc_rmw : cyc_inc;
    wire [63:0] next_retired_ctr = ret_wr ? ret_rmw : ret_inc;

    wallclock_timer u_timer
    (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_time_we(time_wr),
        .i_cmp_we(cmp_wr),
        .i_wdata(timer_wdata),
        .o_time(time_val),
        .o_cmp(cmp_val),
        .o_timer_irq(timer_irq)
    );

    // ======================================================================
    // Read selection
    wire [63:0] rd_pend = hit_s_pend ? 64'(s_pend_view) : 64'(pend_live);
    wire [63:0] rd_en = hit_s_en ? 64'(s_en_view) : 64'(irq_enable);
    wire [63:0] rd_cycle = cycle_ctr;
    wire [63:0] rd_ret = retired_ctr;

    wire [63:0] rd_value =
        (hit_s_pend | hit_m_pend) ? rd_pend :
        (hit_s_en | hit_m_en) ? rd_en :
        hit_gate ? 64'(ctr_gate) :
        hit_scratch ? scratch :
        hit_cmp ? cmp_val :
        (hit_mcycle | hit_cycle) ? rd_cycle :
        (hit_mtime | hit_time) ? time_val :
        (hit_minstret | hit_instret) ? rd_ret :
        `CTR_RESET;

    wire [63:0] next_rdata = illegal ? `CTR_RESET : rd_value;

    wire csr_done = i_csr.valid;

    // ======================================================================
    // Interrupt presentation
    wire [11:0] next_takeable = pend_live & irq_enable;

    wire super_any = |(next_takeable & `SUPER_BITS);
    wire user_any = |(next_takeable & `USER_BITS);

    // User mode always admits supervisor requests; machine mode never does
    wire super_allowed = is_user | (is_super & i_super_global_en);
    wire user_allowed = is_user & i_user_global_en;

    wire next_super_take = super_any & super_allowed;
    wire next_user_take = user_any & user_allowed;

    // ======================================================================
    // Storage
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sw_pend <= `IRQ_RESET;
            irq_enable <= `IRQ_RESET;
        end
        else
        begin
            sw_pend <= next_sw_pend;
            irq_enable <= next_irq_enable;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctr_gate <= `GATE_RESET;
            scratch <= `CTR_RESET;
        end
        else
        begin
            ctr_gate <= next_ctr_gate;
            scratch <= next_scratch;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cycle_ctr <= `CTR_RESET;
            retired_ctr <= `CTR_RESET;
        end
        else
        begin
            cycle_ctr <= next_cycle_ctr;
            retired_ctr <= next_retired_ctr;
        end
    end

    // ======================================================================
    // Registered outputs
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_csr.done <= 1'b0;
            o_csr.illegal <= 1'b0;
            o_csr.rdata <= `CTR_RESET;
        end
        else
        begin
            o_csr.done <= csr_done;
            o_csr.illegal <= illegal;
            o_csr.rdata <= next_rdata;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_irq.super_take <= 1'b0;
            o_irq.user_take <= 1'b0;
            o_irq.takeable <= `IRQ_RESET;
        end
        else
        begin
            o_irq.super_take <= next_super_take;
            o_irq.user_take <= next_user_take;
            o_irq.takeable <= next_takeable;
        end
    end

endmodule // supervisor_interrupt_csrs

// file: src/wallclock_timer.sv
// Free-running real-time counter with a compare register
`include "sup_irq_regs.svh"

module wallclock_timer
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Writes from machine level
    input wire logic i_time_we,
    input wire logic i_cmp_we,
    input wire logic [63:0] i_wdata,
    // State
    output logic [63:0] o_time,
    output logic [63:0] o_cmp,
    output logic o_timer_irq
);

    // ======================================================================
    // Counter and compare
    wire [63:0] next_time = i_time_we ? i_wdata : o_time + 64'h0000_0000_0000_0001;
    wire [63:0] next_cmp = i_cmp_we ? i_wdata : o_cmp;
    // Raising the compare is how software clears the pending timer
    wire next_irq = (next_time >= next_cmp);

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_time <= `CTR_RESET;
            o_cmp <= `CMP_RESET;
            o_timer_irq <= 1'b0;
        end
        else
        begin
            o_time <= next_time;
            o_cmp <= next_cmp;
            o_timer_irq <= next_irq;
        end
    end

endmodule // wallclock_timer
